// file: src/dspxb_params.svh
`ifndef DSPXB_PARAMS_SVH
`define DSPXB_PARAMS_SVH
`define DSPXB_AW 16
`define DSPXB_DW 16
`define DSPXB_ROM_TOP 16'h0FFF
`define DSPXB_Q1 2'h0
`define DSPXB_Q2 2'h1
`define DSPXB_Q3 2'h2
`define DSPXB_Q4 2'h3
`endif

// file: src/dspxb_pkg.sv
package dspxb_pkg;
  typedef enum logic [1:0] {
    DSPXB_SP_DATA = 2'h0,
    DSPXB_SP_PROG = 2'h1,
    DSPXB_SP_IO = 2'h2
  } dspxb_space_e;
  typedef logic [15:0] dspxb_word_t;
endpackage : dspxb_pkg

// file: src/dspxb_sync2.sv
module dspxb_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= INIT;
      q <= INIT;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : dspxb_sync2

// file: src/dspxb_top.sv
// Contract
// [R1] Drive sixteen-bit address bus, msb first, for data, program or I/O space.
// [R2] Data bus driven only with write data; floated in reset or hold.
// [R3] Space selects idle high; only the accessed space goes low.
// [R4] Sample ready at transfer end; low adds one cycle and resamples.
// [R5] Read/write high for read and idle, low only on writes.
// [R6] Strobe idle high, low marks each external bus cycle.
// [R7] Global operand asserts bus request; arbiter answers with ready.
// [R8] Ready after bus request also means the bus was granted.
// [R9] Hold floats data, address, selects, read/write and strobe.
// [R10] Hold acknowledge asserted once hold mode is entered.
// [R11] Sync input is driven low, sampled on input clock rising edge.
// [R12] Microstate done pulses low during clock-a low after each memory operation.
// [R13] Slow memory may build one-wait ready from microstate done.
// [R14] Clock a is input clock over four, rises Q3, falls Q1.
// [R15] Clock b rises Q2, falls Q4.
// [R16] Reset stops work and clears program counter; fetch starts at zero.
// [R17] Interrupt ack low during clock-a low, address bus holds vector.
// [R18] Mode select low maps low 4K program words to internal ROM.
// [R19] Never more than one space select low at once.
`include "dspxb_params.svh"
module dspxb_top (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire dspxb_pkg::dspxb_space_e req_space,
  input wire logic req_write,
  input wire logic req_global,
  input wire logic req_fetch,
  input wire logic req_interrupt_ack_n,
  input wire dspxb_pkg::dspxb_word_t req_addr,
  input wire dspxb_pkg::dspxb_word_t req_wdata,
  input wire logic ready,
  input wire logic hold_n,
  input wire logic sync_n,
  input wire logic memory_mode_select,
  input wire dspxb_pkg::dspxb_word_t data_in,
  output logic req_accept,
  output logic done,
  output dspxb_pkg::dspxb_word_t rdata,
  output logic rom_hit,
  output dspxb_pkg::dspxb_word_t pc,
  output dspxb_pkg::dspxb_word_t addr_out,
  output logic addr_oe,
  output dspxb_pkg::dspxb_word_t data_out,
  output logic data_oe,
  output logic data_space_select_n,
  output logic program_space_select_n,
  output logic io_space_select_n,
  output logic rw,
  output logic transfer_strobe_n,
  output logic ctrl_oe,
  output logic global_bus_request_n,
  output logic hold_acknowledge_n,
  output logic microstate_done_n,
  output logic interrupt_ack_n,
  output logic quarter_clock_a,
  output logic quarter_clock_b
);
  import dspxb_pkg::*;

  typedef enum logic [3:0] {
    DSPXB_IDLE = 4'h1,
    DSPXB_BUS = 4'h2,
    DSPXB_WAIT = 4'h4,
    DSPXB_HOLD = 4'h8
  } dspxb_state_e;

  logic [3:0] pin_s;
  logic ready_s, hold_s, sync_s, mode_s;
  dspxb_word_t din_s;

  // Idle pin levels, so a reset never fakes a hold or a sync edge
  dspxb_sync2 #(.W(4), .INIT(4'h7)) u_sync_ctl (
    .mclk(mclk), .rst_b(rst_b),
    .d({ready, hold_n, sync_n, memory_mode_select}),
    .q(pin_s)
  );
  dspxb_sync2 #(.W(16), .INIT(16'h0000)) u_sync_dat (
    .mclk(mclk), .rst_b(rst_b), .d(data_in), .q(din_s)
  );
  assign ready_s = pin_s[3];
  assign hold_s = ~pin_s[2];
  assign sync_s = ~pin_s[1];
  assign mode_s = pin_s[0];

  // Quarter-phase counter; sync realigns to Q1
  logic [1:0] q_r, q_nxt;
  logic sync_d_r, sync_d_nxt;
  always_comb begin
    q_nxt = q_r + 2'h1;
    sync_d_nxt = sync_s;
    if (sync_s && !sync_d_r) q_nxt = `DSPXB_Q1; // [R11]
  end

  dspxb_state_e st_r, st_nxt;
  dspxb_word_t addr_r, addr_nxt, wd_r, wd_nxt, rd_r, rd_nxt, pc_r, pc_nxt;
  logic [2:0] sel_r, sel_nxt;
  logic wr_r, wr_nxt, stb_r, stb_nxt, oe_r, oe_nxt, doe_r, doe_nxt;
  logic br_r, br_nxt, ha_r, ha_nxt, msc_r, msc_nxt;
  logic acc_r, acc_nxt, done_r, done_nxt, rom_r, rom_nxt, iak_r, iak_nxt;
  logic ca_r, ca_nxt, cb_r, cb_nxt;
  logic is_rom;

  always_comb begin
    is_rom = req_fetch && (req_space == DSPXB_SP_PROG) && !mode_s
             && (req_addr <= `DSPXB_ROM_TOP); // [R18]
    st_nxt = st_r;
    addr_nxt = addr_r;
    wd_nxt = wd_r;
    rd_nxt = rd_r;
    pc_nxt = pc_r;
    sel_nxt = sel_r;
    wr_nxt = wr_r;
    stb_nxt = stb_r;
    oe_nxt = oe_r;
    doe_nxt = 1'b0;
    br_nxt = br_r;
    ha_nxt = ha_r;
    iak_nxt = iak_r;
    acc_nxt = 1'b0;
    done_nxt = 1'b0;
    rom_nxt = 1'b0;
    msc_nxt = 1'b1;
    // Clock outputs: a high in Q3,Q4; b high in Q2,Q3
    ca_nxt = (q_nxt == `DSPXB_Q3) || (q_nxt == `DSPXB_Q4); // [R14]
    cb_nxt = (q_nxt == `DSPXB_Q2) || (q_nxt == `DSPXB_Q3); // [R15]
    case (st_r)
      DSPXB_IDLE: begin
        // Bus completion lands in Q4; stretch into Q1 so it is seen while clock a is low
        if (!msc_r && q_r == `DSPXB_Q4) msc_nxt = 1'b0; // [R12]
        sel_nxt = 3'h7; // [R3]
        wr_nxt = 1'b1; // [R5]
        stb_nxt = 1'b1; // [R6]
        oe_nxt = 1'b1;
        br_nxt = 1'b1;
        ha_nxt = 1'b1;
        iak_nxt = 1'b1;
        if (hold_s) begin
          oe_nxt = 1'b0; // [R9]
          ha_nxt = 1'b0; // [R10]
          st_nxt = DSPXB_HOLD;
        end else if (req_valid && q_r == `DSPXB_Q4) begin
          acc_nxt = 1'b1;
          if (req_fetch) pc_nxt = req_addr + 16'h0001;
          if (is_rom) begin
            done_nxt = 1'b1;
            rom_nxt = 1'b1;
            msc_nxt = 1'b0; // [R12]
          end else begin
            addr_nxt = req_addr; // [R1]
            wd_nxt = req_wdata;
            wr_nxt = ~req_write; // [R5]
            doe_nxt = req_write; // [R2]
            stb_nxt = 1'b0; // [R6]
            sel_nxt = 3'h7;
            sel_nxt[req_space] = 1'b0; // [R3] [R19]
            br_nxt = ~(req_global && req_space == DSPXB_SP_DATA); // [R7]
            iak_nxt = ~req_interrupt_ack_n; // [R17]
            st_nxt = DSPXB_BUS;
          end
        end
      end
      DSPXB_BUS, DSPXB_WAIT: begin
        doe_nxt = ~wr_r; // [R2]
        if (q_r == `DSPXB_Q3) begin
          // End of cycle: ready completes the transfer and grants the bus
          if (ready_s) begin // [R4] [R8]
            rd_nxt = din_s;
            done_nxt = 1'b1;
            msc_nxt = 1'b0; // [R12]
            doe_nxt = 1'b0;
            st_nxt = DSPXB_IDLE;
            sel_nxt = 3'h7;
            stb_nxt = 1'b1;
            wr_nxt = 1'b1;
            br_nxt = 1'b1;
            iak_nxt = 1'b1;
          end else begin
            st_nxt = DSPXB_WAIT; // [R4]
          end
        end
      end
      DSPXB_HOLD: begin
        oe_nxt = 1'b0; // [R9]
        ha_nxt = 1'b0; // [R10]
        if (!hold_s) begin
          oe_nxt = 1'b1;
          ha_nxt = 1'b1;
          st_nxt = DSPXB_IDLE;
        end
      end
      default: st_nxt = DSPXB_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      // Reset floats data, clears pc to zero
      q_r <= `DSPXB_Q1;
      sync_d_r <= 1'b0;
      st_r <= DSPXB_IDLE;
      addr_r <= 16'h0000;
      wd_r <= 16'h0000;
      rd_r <= 16'h0000;
      pc_r <= 16'h0000; // [R16]
      sel_r <= 3'h7;
      wr_r <= 1'b1;
      stb_r <= 1'b1;
      oe_r <= 1'b1;
      doe_r <= 1'b0; // [R2]
      br_r <= 1'b1;
      ha_r <= 1'b1;
      iak_r <= 1'b1;
      acc_r <= 1'b0;
      done_r <= 1'b0;
      rom_r <= 1'b0;
      msc_r <= 1'b1;
      ca_r <= 1'b0;
      cb_r <= 1'b0;
    end else begin
      q_r <= q_nxt;
      sync_d_r <= sync_d_nxt;
      st_r <= st_nxt;
      addr_r <= addr_nxt;
      wd_r <= wd_nxt;
      rd_r <= rd_nxt;
      pc_r <= pc_nxt;
      sel_r <= sel_nxt;
      wr_r <= wr_nxt;
      stb_r <= stb_nxt;
      oe_r <= oe_nxt;
      doe_r <= doe_nxt && !hold_s;
      br_r <= br_nxt;
      ha_r <= ha_nxt;
      iak_r <= iak_nxt;
      acc_r <= acc_nxt;
      done_r <= done_nxt;
      rom_r <= rom_nxt;
      msc_r <= msc_nxt;
      ca_r <= ca_nxt;
      cb_r <= cb_nxt;
    end
  end

  assign req_accept = acc_r;
  assign done = done_r;
  assign rdata = rd_r;
  assign rom_hit = rom_r;
  assign pc = pc_r;
  assign addr_out = addr_r;
  assign addr_oe = oe_r;
  assign data_out = wd_r;
  assign data_oe = doe_r;
  assign data_space_select_n = sel_r[0];
  assign program_space_select_n = sel_r[1];
  assign io_space_select_n = sel_r[2];
  assign rw = wr_r;
  assign transfer_strobe_n = stb_r;
  assign ctrl_oe = oe_r;
  assign global_bus_request_n = br_r;
  assign hold_acknowledge_n = ha_r;
  assign microstate_done_n = msc_r;
  assign interrupt_ack_n = iak_r;
  assign quarter_clock_a = ca_r;
  assign quarter_clock_b = cb_r;
endmodule : dspxb_top

// file: verif/dsp_external_bus_interface_bench.sv
`define CHK(x, y) begin comparisons++; if ((x) !== (y)) begin mismatches++; \
  $display("[FAIL] %0t %h %h", $time, x, y); end end
module dsp_external_bus_interface_bench;
  import dspxb_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0, rst_b = 1'b0, req_valid = 1'b0, req_write = 1'b0, req_global = 1'b0;
  logic req_fetch = 1'b0, req_interrupt_ack_n = 1'b0, hold_n = 1'b1, sync_n = 1'b1;
  logic memory_mode_select = 1'b0, ready, req_accept, done, rom_hit, addr_oe, data_oe;
  logic data_space_select_n, program_space_select_n, io_space_select_n, rw, transfer_strobe_n;
  logic ctrl_oe, global_bus_request_n, hold_acknowledge_n, microstate_done_n, interrupt_ack_n;
  logic quarter_clock_a, quarter_clock_b;
  logic [1:0] waits = 2'h0;
  dspxb_space_e req_space = DSPXB_SP_DATA;
  dspxb_word_t req_addr = 16'h0000, req_wdata = 16'h0000, data_in, rdata, pc, addr_out, data_out;
  logic [15:0] s = 16'h4216;
  int mismatches = 0, comparisons = 0, n;
  dspxb_top dut (.*);
  dspxb_mem mem (.mclk, .strobe_n(transfer_strobe_n), .rd(rw), .addr(addr_out), .waits,
    .ready, .data(data_in));
  always #5 mclk = ~mclk;
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr
  function automatic dspxb_word_t exp_rd(input dspxb_word_t a);
    return a ^ 16'h5A3C;
  endfunction : exp_rd
  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim
  task automatic xfer(input dspxb_space_e sp, input logic wr, gl, fe, ia, input dspxb_word_t a,
    input logic [1:0] w);
    @(negedge mclk);
    {req_write, req_global, req_fetch, req_interrupt_ack_n, waits} = {wr, gl, fe, ia, w};
    req_space = sp;
    req_addr = a;
    req_wdata = ~a;
    req_valid = 1'b1;
    n = 0;
    while (req_accept !== 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    req_valid = 1'b0;
    if (fe && !memory_mode_select && a < 16'h1000) begin
      `CHK({rom_hit, done, transfer_strobe_n}, 3'h7)
    end else begin
      `CHK({data_space_select_n, program_space_select_n, io_space_select_n}, ~(3'h4 >> sp))
      `CHK({transfer_strobe_n, rw, data_oe}, {1'b0, !wr, wr})
      `CHK({global_bus_request_n, interrupt_ack_n}, {!gl, !ia})
      `CHK(addr_out, a)
      if (wr) `CHK(data_out, ~a)
      n = 0;
      while (done !== 1'b1 && n < 40) begin
        @(negedge mclk);
        n++;
      end
      `CHK(n == 3 + 4 * w, 1'b1)
      if (!wr) `CHK(rdata, exp_rd(a))
    end
    if (fe) `CHK(pc, a + 16'h0001)
  endtask : xfer
  initial begin
    // Second pass resets mid-run with pc left at 16'h1000 by the fetch
    repeat (2) begin
      rst_b = 1'b0;
      repeat (3) @(negedge mclk);
      rst_b = 1'b1;
      `CHK({pc, transfer_strobe_n, rw, data_space_select_n}, {16'h0000, 3'h7})
      repeat (4) @(negedge mclk);
      xfer(DSPXB_SP_PROG, 1'b0, 1'b0, 1'b1, 1'b0, 16'h0FFF, 2'h0);
    end
    memory_mode_select = 1'b1;
    repeat (4) @(negedge mclk);
    xfer(DSPXB_SP_PROG, 1'b0, 1'b0, 1'b1, 1'b0, 16'h0FFF, 2'h1);
    xfer(DSPXB_SP_PROG, 1'b0, 1'b0, 1'b0, 1'b1, 16'h0002, 2'h0);
    xfer(DSPXB_SP_DATA, 1'b1, 1'b1, 1'b0, 1'b0, 16'h8001, 2'h2);
    repeat (40) begin
      s = lfsr(s);
      xfer(dspxb_space_e'(s[1:0] == 2'h3 ? 2'h0 : s[1:0]), s[2], s[3] & ~|s[1:0], 1'b0,
        1'b0, lfsr(s ^ 16'h1357), s[5:4]);
    end
    @(negedge mclk);
    hold_n = 1'b0;
    n = 0;
    while (hold_acknowledge_n !== 1'b0 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    `CHK({hold_acknowledge_n, addr_oe, data_oe, ctrl_oe}, 4'h0)
    hold_n = 1'b1;
    repeat (8) @(negedge mclk);
    // Sync in Q3: free running would give Q2 three edges on, sync forces Q1
    while ({quarter_clock_a, quarter_clock_b} !== 2'h3) @(negedge mclk);
    sync_n = 1'b0;
    repeat (3) @(negedge mclk);
    `CHK({quarter_clock_a, quarter_clock_b}, 2'h0)
    @(negedge mclk);
    `CHK({quarter_clock_a, quarter_clock_b}, 2'h1)
    repeat (3) @(negedge mclk);
    sync_n = 1'b1;
    xfer(DSPXB_SP_IO, 1'b1, 1'b0, 1'b0, 1'b0, 16'hFFFF, 2'h3);
    end_sim();
  end
  // Generous bound: about seven hundred cycles of traffic expected
  initial begin
    #50000;
    mismatches++;
    end_sim();
  end
endmodule : dsp_external_bus_interface_bench

// file: verif/dspxb_chk.sv
module dspxb_chk (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic sync_n,
  input wire logic ready,
  input wire logic done,
  input wire logic rom_hit,
  input wire logic data_oe,
  input wire logic ctrl_oe,
  input wire logic data_space_select_n,
  input wire logic program_space_select_n,
  input wire logic io_space_select_n,
  input wire logic rw,
  input wire logic transfer_strobe_n,
  input wire logic global_bus_request_n,
  input wire logic hold_acknowledge_n,
  input wire logic microstate_done_n,
  input wire logic quarter_clock_a,
  input wire logic quarter_clock_b
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  wire [2:0] sel = {data_space_select_n, program_space_select_n, io_space_select_n};
  a_sel_onehot: assert property ($countones(~sel) <= 1) else $error("two selects low");
  a_idle_high: assert property (transfer_strobe_n && ctrl_oe |-> &sel && rw)
    else $error("idle level wrong");
  a_write_drive: assert property (data_oe |-> !rw && !transfer_strobe_n)
    else $error("data driven outside write");
  a_hold_float: assert property (!hold_acknowledge_n |-> !data_oe && !ctrl_oe)
    else $error("bus driven in hold");
  // A sync restart cuts the phase short, so shape checks rest while sync is held
  a_clk_shape: assert property (disable iff (!rst_b || !sync_n)
    $rose(quarter_clock_a) |=> quarter_clock_a ##1 (!quarter_clock_a)[*2] ##1 quarter_clock_a)
    else $error("clock a shape");
  a_clk_phase: assert property (disable iff (!rst_b || !sync_n)
    $rose(quarter_clock_b) |=> $rose(quarter_clock_a) ##1 $fell(quarter_clock_b))
    else $error("clock b phase");
  // Two synchroniser stages plus the decision edge: ready is read three edges before done
  a_ready_wait: assert property (done && !rom_hit |-> $past(ready, 3))
    else $error("done without ready");
  // Bus completions stretch the pulse into the next Q1; ROM hits already land there
  a_msc_pulse: assert property (done && !rom_hit |-> (!microstate_done_n)[*2] ##1 microstate_done_n)
    else $error("microstate pulse");
  a_msc_rom: assert property (done && rom_hit |-> !microstate_done_n ##1 microstate_done_n)
    else $error("microstate pulse on rom hit");
  a_msc_phase: assert property (done |-> ##[0:1] (!microstate_done_n && !quarter_clock_a))
    else $error("microstate pulse outside clock a low");
  a_br_data: assert property (!global_bus_request_n |-> !data_space_select_n)
    else $error("request outside data");
endmodule : dspxb_chk
bind dspxb_top dspxb_chk chk (.*);

// file: verif/dspxb_mem.sv
module dspxb_mem (
  input wire logic mclk,
  input wire logic strobe_n,
  input wire logic rd,
  input wire dspxb_pkg::dspxb_word_t addr,
  input wire logic [1:0] waits,
  output logic ready,
  output dspxb_pkg::dspxb_word_t data
);
  import dspxb_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_r = 4'h0;
  dspxb_word_t last_r = 16'h0000;
  always @(posedge mclk) cnt_r <= strobe_n ? 4'h0 : cnt_r + 4'h1;
  always @(posedge mclk) last_r <= data;
  // Slow memory: one machine cycle of wait per step of waits
  assign ready = !strobe_n && cnt_r >= {waits, 2'h0};
  // Released bus toggles so a stale word never looks valid
  assign data = (!strobe_n && rd) ? addr ^ 16'h5A3C : ~last_r;
endmodule : dspxb_mem
